// ### dv/board_model.sv
// Board-side model: pin pull-ups, expander interrupts, boot clock wire
`timescale 1ns/1ps

module board_model (
    input  wire logic [7:0] gpioOut,
    input  wire logic [7:0] gpioOe,
    input  wire logic       bootBusClkOut,
    input  wire logic       bootBusClkOe,
    input  wire logic [1:0] expanderIrq,
    output logic      [7:0] gpioWire,
    output logic            bootClkWire
);
    // ------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------
    // expander lines pull low
    always_comb begin
        gpioWire = 8'hff;
        for (int i = 0; i < 8; i++) begin
            if (gpioOe[i]) begin
                gpioWire[i] = gpioOut[i];
            end
        end
        // Open-drain expanders win over any driver
        if (expanderIrq[0]) begin
            gpioWire[2] = 1'b0;
        end
        if (expanderIrq[1]) begin
            gpioWire[4] = 1'b0;
        end
    end

    assign bootClkWire = bootBusClkOe ? bootBusClkOut : 1'b1;
endmodule

// ### dv/switch_reset_boot_strap_control_bench.sv
// Self-checking bench for the reset and boot-strap control block
`timescale 1ns/1ps
`include "reset_strap_params.svh"

module switch_reset_boot_strap_control_bench;
    logic        clk;
    logic        resetn;
    logic [3:0]  eeAddr;
    logic [3:0]  tgtAddr;
    logic [3:0]  modeStrap;
    logic        slowSel;
    logic        ccDown;
    logic        ccUp;
    logic        holdReq;
    logic [3:0]  regAddr;
    logic [31:0] regWdata;
    logic        regWr;
    logic        regRd;
    logic [31:0] regRdata;
    logic [7:0]  gpioOut;
    logic [7:0]  gpioOe;
    logic [7:0]  gpioWire;
    logic        bootBusClkOut;
    logic        bootBusClkOe;
    logic        bootClkWire;
    logic        linkResetReq;
    logic        coreRunning;
    logic        irq;
    logic [1:0]  expanderIrq;
    logic [31:0] rdv;
    logic [7:0]  oeV;
    logic [7:0]  outV;
    integer      seed;
    int          nFail;
    int          comparisons;
    int          n;

    switch_reset_strap dut (
        .clk(clk), .resetn(resetn), .eeprom_bus_addr_strap(eeAddr),
        .target_bus_addr_strap(tgtAddr), .switch_mode_strap(modeStrap),
        .boot_bus_slow_sel(slowSel), .shared_refclk_down(ccDown),
        .shared_refclk_up(ccUp), .reset_hold(holdReq), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .gpioIn(gpioWire), .gpioOut(gpioOut),
        .gpioOe(gpioOe), .bootBusClkOut(bootBusClkOut),
        .bootBusClkOe(bootBusClkOe), .linkResetReq(linkResetReq),
        .coreRunning(coreRunning), .irq(irq));

    board_model board (
        .gpioOut(gpioOut), .gpioOe(gpioOe), .bootBusClkOut(bootBusClkOut),
        .bootBusClkOe(bootBusClkOe), .expanderIrq(expanderIrq),
        .gpioWire(gpioWire), .bootClkWire(bootClkWire));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Tasks and expectations
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, nFail);
        if (nFail == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            nFail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk);
        regWr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd   <= 1'b0;
        #1;
        d = regRdata;
    endtask

    task automatic settle;
        @(posedge clk);
        #1;
    endtask

    // Bounded wait on a bench-visible condition
    task automatic waitFor(input bit boot, input logic lvl, input int bound,
                           output int cnt);
        cnt = 0;
        while ((boot ? bootClkWire : coreRunning) !== lvl && cnt < bound) begin
            settle();
            cnt++;
        end
        if ((boot ? bootClkWire : coreRunning) !== lvl) begin
            nFail++;
            $display("unexpected timeout waiting on level %b", lvl);
            end_of_test();
        end
    endtask

    task automatic doReset(input logic hold, input logic [3:0] mode,
                           input logic slow);
        @(posedge clk);
        resetn    <= 1'b0;
        holdReq   <= hold;
        modeStrap <= mode;
        slowSel   <= slow;
        eeAddr    <= 4'($random(seed));
        tgtAddr   <= 4'($random(seed));
        ccDown    <= 1'($random(seed));
        ccUp      <= 1'($random(seed));
        repeat (2) @(posedge clk);
        #1;
        chk("link reset held", 32'h1, {31'h0, linkResetReq});
        chk("running in reset", 32'h0, {31'h0, coreRunning});
        chk("pin enables in reset", 32'h0, {24'h0, gpioOe});
        @(posedge clk);
        resetn <= 1'b1;
    endtask

    function automatic logic [31:0] strapsExp();
        logic [31:0] v;
        v = 32'h0;
        v[4:1]   = eeAddr;
        v[10]    = tgtAddr[3];
        v[8:6]   = tgtAddr[2:0];
        v[16:13] = modeStrap;
        v[17]    = slowSel;
        v[18]    = ccDown;
        v[19]    = ccUp;
        v[20]    = modeStrap > 4'h1;
        return v;
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'heb95;
        nFail = 0;
        comparisons = 0;
        resetn = 1'b0;
        {eeAddr, tgtAddr, modeStrap} = 12'h0;
        {slowSel, ccDown, ccUp, holdReq, regWr, regRd} = 6'h0;
        regAddr = 4'h0;
        regWdata = 32'h0;
        expanderIrq = 2'h0;
        repeat (2) @(posedge clk);
        // normal and reserved modes run without boot burst
        for (int k = 0; k < 4; k++) begin
            doReset(1'b0, (k == 0) ? 4'h0 : 4'(2 + {$random(seed)} % 14),
                    1'($random(seed)));
            waitFor(1'b0, 1'b1, 40, n);
            rd(`REG_STATUS, rdv);
            chk("state after reset", 32'h8, rdv);
            rd(`REG_STRAPS, rdv);
            chk("strap capture", strapsExp(), rdv & 32'h001fe5de);
        end
        // boot burst clock rate and idle afterwards
        for (int s = 0; s < 2; s++) begin
            doReset(1'b0, `MODE_EEPROM, s[0]);
            waitFor(1'b1, 1'b0, 200, n);
            rd(`REG_STATUS, rdv);
            chk("state in boot", 32'h4, rdv);
            waitFor(1'b1, 1'b1, 200, n);
            waitFor(1'b1, 1'b0, 200, n);
            waitFor(1'b1, 1'b1, 200, n);
            chk("boot half period", s ? `SLOW_HALF : `FAST_HALF, n);
            waitFor(1'b0, 1'b1, 4000, n);
            n = 0;
            repeat (100) begin
                settle();
                n += bootBusClkOe;
            end
            chk("boot clock idle", 32'h0, n);
        end
        doReset(1'b1, 4'h0, 1'b0);
        repeat (24) settle();
        rd(`REG_STATUS, rdv);
        chk("halt state", 32'h2, rdv);
        chk("link reset in halt", 32'h1, {31'h0, linkResetReq});
        rd(`REG_CTRL, rdv);
        chk("halt bit set", 32'h1, rdv & 32'h1);
        wr(`REG_IRQ_MASK, 32'h5);
        rd(`REG_IRQ_MASK, rdv);
        chk("mask in halt", 32'h5, rdv & 32'h7);
        wr(`REG_CTRL, 32'h0);
        waitFor(1'b0, 1'b1, 5, n);
        chk("running after halt clear", 32'h1, {31'h0, coreRunning});
        settle();
        chk("irq on run entry", 32'h1, {31'h0, irq});
        wr(`REG_IRQ_STAT, 32'h4);
        settle();
        chk("irq after clear", 32'h0, {31'h0, irq});
        // plain GPIO with random drive and pull-ups
        wr(`REG_GPIO_ALT, 32'h0);
        for (int k = 0; k < 4; k++) begin
            oeV  = 8'($random(seed));
            outV = 8'($random(seed));
            wr(`REG_GPIO_OE, {24'h0, oeV});
            wr(`REG_GPIO_OUT, {24'h0, outV});
            settle();
            rd(`REG_GPIO_IN, rdv);
            chk("plain pin levels", {24'h0, (outV & oeV) | ~oeV}, rdv);
        end
        // alternate outputs follow control bits, active low
        wr(`REG_GPIO_OE, 32'h0);
        wr(`REG_GPIO_ALT, 32'hff);
        for (int b = 1; b < 4; b++) begin
            wr(`REG_CTRL, 32'h1 << b);
            settle();
            chk("alt outputs", {24'h0, 8'h83 & ~{b == 3, 5'h0, b == 2, b == 1}},
                {24'h0, gpioWire & 8'h83});
        end
        wr(`REG_CTRL, 32'h0);
        for (int e = 0; e < 2; e++) begin
            @(posedge clk);
            expanderIrq <= 2'h1 << e;
            repeat (3) settle();
            @(posedge clk);
            expanderIrq <= 2'h0;
            rd(`REG_IRQ_STAT, rdv);
            chk("expander event", 32'h1 << e, rdv & 32'h3);
            chk("irq level", {31'h0, e == 0}, {31'h0, irq});
            wr(`REG_IRQ_STAT, 32'h3);
            settle();
            chk("irq cleared", 32'h0, {31'h0, irq});
        end
        // Unmapped place reads zero, write ignored
        wr(4'hf, 32'hffffffff);
        rd(4'hf, rdv);
        chk("unmapped read", 32'h0, rdv);
        // software-started burst in run, then quiet
        wr(`REG_BOOT_CMD, 32'h1);
        rd(`REG_BOOT_CMD, rdv);
        chk("boot busy", 32'h1, rdv);
        waitFor(1'b1, 1'b0, 40, n);
        repeat (240) settle();
        rd(`REG_BOOT_CMD, rdv);
        chk("boot done", 32'h0, rdv);
        chk("boot clock released", 32'h0, {31'h0, bootBusClkOe});
        end_of_test();
    end
endmodule

// ### rtl/reset_strap_params.svh
// Constants for the reset and boot-strap control block
`ifndef RESET_STRAP_PARAMS_SVH
`define RESET_STRAP_PARAMS_SVH

// Register offsets on the plain register port
`define REG_CTRL        4'h0
`define REG_STRAPS      4'h1
`define REG_GPIO_ALT    4'h2
`define REG_GPIO_OE     4'h3
`define REG_GPIO_OUT    4'h4
`define REG_GPIO_IN     4'h5
`define REG_IRQ_STAT    4'h6
`define REG_IRQ_MASK    4'h7
`define REG_BOOT_CMD    4'h8
`define REG_STATUS      4'h9

// Control register fields
`define CTRL_HALT_BIT   0
`define CTRL_PRST_A_BIT 1
`define CTRL_PRST_B_BIT 2
`define CTRL_EVENT_BIT  3

// Interrupt status fields
`define IRQ_EXP0_BIT    0
`define IRQ_EXP2_BIT    1
`define IRQ_RUN_BIT     2

// Boot-bus command field
`define BOOT_GO_BIT     0

// Switch mode encodings
`define MODE_NORMAL     4'h0
`define MODE_EEPROM     4'h1

// GPIO pin roles in alternate function
`define PIN_PRST_A      0
`define PIN_PRST_B      1
`define PIN_EXP0        2
`define PIN_EXP2        4
`define PIN_EVENT       7

// Boot bus rates and core clock
`define CLK_HZ          10000000
`define SLOW_HZ         100000
`define FAST_HZ         400000
// Half period in cycles, rounded down so the rate never runs slow
`define SLOW_HALF       (`CLK_HZ / (2 * `SLOW_HZ))
`define FAST_HALF       (`CLK_HZ / (2 * `FAST_HZ))

// Reset procedure length in cycles
`define RESET_CYCLES    16
// Length of the boot-bus access burst in clock toggles
`define BOOT_TOGGLES    18

`endif

// ### rtl/reset_strap_pkg.sv
// Types for the reset and boot-strap control block
package reset_strap_pkg;
    typedef enum logic [3:0] {
        ST_RESET = 4'b0001,
        ST_HALT  = 4'b0010,
        ST_BOOT  = 4'b0100,
        ST_RUN   = 4'b1000
    } seq_state_t;
endpackage

// ### rtl/switch_reset_strap.sv
// Reset sequencer, strap capture, boot-bus clock and GPIO muxing
//
// Functional notes
// - EEPROM bus address from four straps
// - Boot bus clock toggles only during access
// - Target bus address from straps 5,3:1
// - Slow strap picks 100 kHz, else 400
// - Pins are plain GPIO unless alternate
// - Pins 0,1 drive downstream port resets
// - Pins 2,4 take expander interrupts
// - Pin 7 drives active-low event output
// - Downstream shared-clock strap reported
// - Upstream shared-clock strap reported
// - Fundamental reset clears all logic
// - Hold strap keeps device halted in reset
// - Clearing halt bit starts normal operation
// - Mode strap: 0 normal, 1 EEPROM, others reserved
// - Names ending n are active low
`timescale 1ns/1ps
`include "reset_strap_params.svh"

module switch_reset_strap #(
    parameter int GPIO_W = 8
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [3:0]        eeprom_bus_addr_strap,
    input  wire logic [3:0]        target_bus_addr_strap,
    input  wire logic [3:0]        switch_mode_strap,
    input  wire logic              boot_bus_slow_sel,
    input  wire logic              shared_refclk_down,
    input  wire logic              shared_refclk_up,
    input  wire logic              reset_hold,
    input  wire logic [3:0]        regAddr,
    input  wire logic [31:0]       regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [31:0]       regRdata,
    input  wire logic [GPIO_W-1:0] gpioIn,
    output logic      [GPIO_W-1:0] gpioOut,
    output logic      [GPIO_W-1:0] gpioOe,
    output logic                   bootBusClkOut,
    output logic                   bootBusClkOe,
    output logic                   linkResetReq,
    output logic                   coreRunning,
    output logic                   irq
);

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    logic [3:0] eeAddr_q;
    logic [6:0] tgtAddr_q;
    logic [3:0] mode_q;
    logic       slow_q;
    logic       ccDown_q;
    logic       ccUp_q;
    logic       hold_q;
    logic       captured_q;
    reset_strap_pkg::seq_state_t state_q;
    logic [7:0] rstCnt_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            captured_q <= 1'b0;
            eeAddr_q   <= 4'h0;
            tgtAddr_q  <= 7'h00;
            mode_q     <= 4'h0;
            slow_q     <= 1'b0;
            ccDown_q   <= 1'b0;
            ccUp_q     <= 1'b0;
            hold_q     <= 1'b0;
        end else if (!captured_q) begin
            captured_q <= 1'b1;
            eeAddr_q   <= eeprom_bus_addr_strap;
            tgtAddr_q  <= {1'b0, target_bus_addr_strap[3], 1'b0,
                           target_bus_addr_strap[2:0], 1'b0};
            mode_q     <= switch_mode_strap;
            slow_q     <= boot_bus_slow_sel;
            ccDown_q   <= shared_refclk_down;
            ccUp_q     <= shared_refclk_up;
            hold_q     <= reset_hold;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [3:0]        ctrl_q;
    logic [GPIO_W-1:0] alt_q;
    logic [GPIO_W-1:0] oe_q;
    logic [GPIO_W-1:0] out_q;
    logic [2:0]        stat_q;
    logic [2:0]        mask_q;
    logic              bootGo_q;
    logic              bootBusy_q;
    logic              wrCtrl;
    logic              eepromMode;
    logic              modeReserved;

    assign wrCtrl       = regWr && (regAddr == `REG_CTRL);
    assign eepromMode   = (mode_q == `MODE_EEPROM);
    assign modeReserved = (mode_q != `MODE_NORMAL) && !eepromMode;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= 4'h0;
        end else if (state_q == reset_strap_pkg::ST_RESET
                     && rstCnt_q == 8'(`RESET_CYCLES - 1)) begin
            ctrl_q[`CTRL_HALT_BIT] <= hold_q;
        end else if (wrCtrl) begin
            ctrl_q <= regWdata[3:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alt_q <= '0;
            oe_q  <= '0;
            out_q <= '0;
            mask_q <= 3'h0;
        end else if (regWr) begin
            if (regAddr == `REG_GPIO_ALT) alt_q <= regWdata[GPIO_W-1:0];
            if (regAddr == `REG_GPIO_OE) oe_q <= regWdata[GPIO_W-1:0];
            if (regAddr == `REG_GPIO_OUT) out_q <= regWdata[GPIO_W-1:0];
            if (regAddr == `REG_IRQ_MASK) mask_q <= regWdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    logic bootStart;
    assign bootStart = bootGo_q && !bootBusy_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q  <= reset_strap_pkg::ST_RESET;
            rstCnt_q <= 8'h00;
        end else begin
            case (state_q)
                reset_strap_pkg::ST_RESET: begin
                    if (rstCnt_q == 8'(`RESET_CYCLES - 1)) begin
                        if (hold_q)
                            state_q <= reset_strap_pkg::ST_HALT;
                        else if (eepromMode)
                            state_q <= reset_strap_pkg::ST_BOOT;
                        else
                            state_q <= reset_strap_pkg::ST_RUN;
                    end else begin
                        rstCnt_q <= rstCnt_q + 8'h01;
                    end
                end
                reset_strap_pkg::ST_HALT: begin
                    if (!ctrl_q[`CTRL_HALT_BIT])
                        state_q <= eepromMode ? reset_strap_pkg::ST_BOOT
                                              : reset_strap_pkg::ST_RUN;
                end
                reset_strap_pkg::ST_BOOT: begin
                    if (!bootBusy_q && !bootGo_q)
                        state_q <= reset_strap_pkg::ST_RUN;
                end
                reset_strap_pkg::ST_RUN: state_q <= reset_strap_pkg::ST_RUN;
                default: state_q <= reset_strap_pkg::ST_RESET;
            endcase
        end
    end

    assign linkResetReq = (state_q == reset_strap_pkg::ST_RESET)
                       || (state_q == reset_strap_pkg::ST_HALT);
    assign coreRunning  = (state_q == reset_strap_pkg::ST_RUN);

    // ------------------------------------------------------------
    // Boot bus clock
    // ------------------------------------------------------------
    logic [7:0] divCnt_q;
    logic [7:0] toggles_q;
    logic       sclk_q;
    logic [7:0] halfCnt;
    logic       enterBoot;

    // Half period chosen by slow strap
    assign halfCnt = slow_q ? 8'(`SLOW_HALF) : 8'(`FAST_HALF);
    assign enterBoot = eepromMode && ((state_q == reset_strap_pkg::ST_HALT
        && !ctrl_q[`CTRL_HALT_BIT]) || (!hold_q && rstCnt_q ==
        8'(`RESET_CYCLES - 1) && state_q == reset_strap_pkg::ST_RESET));

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bootGo_q <= 1'b0;
        end else if (enterBoot || (regWr && regAddr == `REG_BOOT_CMD
                     && regWdata[`BOOT_GO_BIT])) begin
            bootGo_q <= 1'b1;
        end else if (bootStart) begin
            bootGo_q <= 1'b0;
        end
    end

    // Clock runs only during an access burst
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bootBusy_q <= 1'b0;
            divCnt_q   <= 8'h00;
            toggles_q  <= 8'h00;
            sclk_q     <= 1'b1;
        end else if (bootStart) begin
            bootBusy_q <= 1'b1;
            divCnt_q   <= 8'h00;
            toggles_q  <= 8'h00;
        end else if (bootBusy_q) begin
            if (divCnt_q == halfCnt - 8'h01) begin
                divCnt_q  <= 8'h00;
                sclk_q    <= ~sclk_q;
                toggles_q <= toggles_q + 8'h01;
                if (toggles_q == 8'(`BOOT_TOGGLES - 1))
                    bootBusy_q <= 1'b0;
            end else begin
                divCnt_q <= divCnt_q + 8'h01;
            end
        end else begin
            sclk_q <= 1'b1;
        end
    end

    // Open drain: drive only to pull low
    assign bootBusClkOut = 1'b0;
    assign bootBusClkOe  = bootBusy_q && !sclk_q;

    // ------------------------------------------------------------
    // GPIO and alternate functions
    // ------------------------------------------------------------
    logic [GPIO_W-1:0] altOut;
    logic [GPIO_W-1:0] altOe;

    always_comb begin
        altOut = '0;
        altOe  = '0;
        // Port resets held while not running
        altOut[`PIN_PRST_A] = coreRunning && !ctrl_q[`CTRL_PRST_A_BIT];
        altOut[`PIN_PRST_B] = coreRunning && !ctrl_q[`CTRL_PRST_B_BIT];
        altOe[`PIN_PRST_A]  = 1'b1;
        altOe[`PIN_PRST_B]  = 1'b1;
        // Event pin low while event set
        altOut[`PIN_EVENT]  = !ctrl_q[`CTRL_EVENT_BIT];
        altOe[`PIN_EVENT]   = 1'b1;
    end

    genvar gi;
    generate
        for (gi = 0; gi < GPIO_W; gi++) begin : g_pin
            assign gpioOut[gi] = alt_q[gi] ? altOut[gi] : out_q[gi];
            assign gpioOe[gi]  = alt_q[gi] ? altOe[gi] : oe_q[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    logic [2:0] evt;
    logic [2:0] clr;
    logic       runSeen_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) runSeen_q <= 1'b0;
        else         runSeen_q <= coreRunning;
    end

    assign evt[`IRQ_EXP0_BIT] = alt_q[`PIN_EXP0] && !gpioIn[`PIN_EXP0];
    assign evt[`IRQ_EXP2_BIT] = alt_q[`PIN_EXP2] && !gpioIn[`PIN_EXP2];
    assign evt[`IRQ_RUN_BIT]  = coreRunning && !runSeen_q;
    assign clr = (regWr && regAddr == `REG_IRQ_STAT) ? regWdata[2:0] : 3'h0;

    // Set wins over a same-cycle clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) stat_q <= 3'h0;
        else         stat_q <= (stat_q & ~clr) | evt;
    end

    assign irq = |(stat_q & mask_q);

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            regRdata <= 32'h0;
        end else if (regRd) begin
            case (regAddr)
                `REG_CTRL:     regRdata <= {28'h0, ctrl_q};
                `REG_STRAPS:   regRdata <= {11'h0, modeReserved, ccUp_q,
                                            ccDown_q, slow_q, mode_q,
                                            1'b0, tgtAddr_q,
                                            eeAddr_q, 1'b0};
                `REG_GPIO_ALT: regRdata <= 32'(alt_q);
                `REG_GPIO_OE:  regRdata <= 32'(oe_q);
                `REG_GPIO_OUT: regRdata <= 32'(out_q);
                `REG_GPIO_IN:  regRdata <= 32'(gpioIn);
                `REG_IRQ_STAT: regRdata <= {29'h0, stat_q};
                `REG_IRQ_MASK: regRdata <= {29'h0, mask_q};
                `REG_BOOT_CMD: regRdata <= {31'h0, bootBusy_q};
                `REG_STATUS:   regRdata <= {28'h0, state_q};
                default:       regRdata <= 32'h0;
            endcase
        end else begin
            regRdata <= 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    localparam int slowHalfCyc = `SLOW_HALF;

    a_clk_idle_quiet: assert property (
        !bootBusy_q && !bootGo_q |=> !bootBusClkOe)
        else $error("boot bus clock driven while idle");
    a_halt_blocks_run: assert property (
        ctrl_q[`CTRL_HALT_BIT] && state_q == reset_strap_pkg::ST_HALT
        |=> state_q != reset_strap_pkg::ST_RUN)
        else $error("left halt with halt bit set");
    a_halt_exit_run: assert property (
        state_q == reset_strap_pkg::ST_HALT && !ctrl_q[`CTRL_HALT_BIT]
        && !eepromMode |=> coreRunning)
        else $error("halt did not exit");
    a_hold_enters_halt: assert property (
        state_q == reset_strap_pkg::ST_RESET
        && rstCnt_q == 8'(`RESET_CYCLES - 1) && hold_q
        |=> state_q == reset_strap_pkg::ST_HALT && ctrl_q[`CTRL_HALT_BIT])
        else $error("hold strap ignored");
    a_prst_held_reset: assert property (
        alt_q[`PIN_PRST_A] && !coreRunning
        |-> gpioOe[`PIN_PRST_A] && !gpioOut[`PIN_PRST_A])
        else $error("port reset released early");
    a_event_pin_low: assert property (
        alt_q[`PIN_EVENT] && ctrl_q[`CTRL_EVENT_BIT]
        |-> gpioOe[`PIN_EVENT] && !gpioOut[`PIN_EVENT])
        else $error("event pin not low");
    a_exp_irq_set: assert property (
        alt_q[`PIN_EXP0] && !gpioIn[`PIN_EXP0] |=> stat_q[`IRQ_EXP0_BIT])
        else $error("expander interrupt lost");
    a_plain_gpio_out: assert property (
        !alt_q[3] |-> gpioOut[3] == out_q[3] && gpioOe[3] == oe_q[3])
        else $error("plain gpio path wrong");
    a_clk_half_slow: assert property (
        bootBusy_q && slow_q && $changed(sclk_q) |-> ##slowHalfCyc
        ($changed(sclk_q) || !bootBusy_q)) else $error("slow rate wrong");
    a_reset_len: assert property (
        $rose(captured_q) |-> linkResetReq [*8])
        else $error("reset phase too short");

    c_halt_seen: cover property (state_q == reset_strap_pkg::ST_HALT);
    c_boot_burst: cover property ($fell(bootBusy_q));
    c_run_reached: cover property ($rose(coreRunning));
    c_irq_raised: cover property ($rose(irq));

endmodule
